// ### verilog/wcnt_defines.svh
// Register offsets, field positions, reset values and codes of the wide counter block.
`ifndef WCNT_DEFINES_SVH
`define WCNT_DEFINES_SVH

// Byte addresses of the APB registers.
`define WCNT_OFS_WIDE_CTRL 8'h00
`define WCNT_OFS_SHARED_CTRL 8'h04
`define WCNT_OFS_RELOAD_HIGH 8'h08
`define WCNT_OFS_RELOAD_LOW 8'h0C
`define WCNT_OFS_CAPTURE_HIGH 8'h10
`define WCNT_OFS_CAPTURE_LOW 8'h14

// Wide control register fields.
`define WCNT_CTL_ENABLE 7
`define WCNT_CTL_SINGLE 6
`define WCNT_CTL_TIMEOUT 5
`define WCNT_CTL_CLK_HI 4
`define WCNT_CTL_CLK_LO 3
`define WCNT_CTL_CAP_MASK 2
`define WCNT_CTL_CNT_MASK 1
`define WCNT_CTL_PIN_SEL 0

// Shared timer control register fields.
`define WCNT_SHR_DEMOD 6
`define WCNT_SHR_EDGE_HI 5
`define WCNT_SHR_EDGE_LO 4
`define WCNT_SHR_OMODE_HI 3
`define WCNT_SHR_OMODE_LO 2
`define WCNT_SHR_RISE 1
`define WCNT_SHR_FALL 0

// Reset values and constants of the counting logic.
`define WCNT_RST_BYTE 8'h00
`define WCNT_RST_COUNT 16'h0000
`define WCNT_ONE 16'h0001
`define WCNT_ALL_ONES 16'hFFFF
`define WCNT_RST_DIV 3'h0
`define WCNT_BYTE_SHIFT 8

`endif

// ### verilog/wcnt_pkg.sv
// Types used only by the wide counter design.
`default_nettype none
package wcnt_pkg;

	// Output mode field: normal, alternating, forced low, forced high.
	typedef enum logic [1:0] {
		OMODE_NORMAL = 2'h0,
		OMODE_ALTERNATE = 2'h1,
		OMODE_FORCE_LOW = 2'h2,
		OMODE_FORCE_HIGH = 2'h3
	} omode_e;

	// Count clock divider select.
	typedef enum logic [1:0] {
		CLK_DIV1 = 2'h0,
		CLK_DIV2 = 2'h1,
		CLK_DIV4 = 2'h2,
		CLK_DIV8 = 2'h3
	} clk_sel_e;

	// Complete state of the wide counter block.
	typedef struct packed {
		logic enable;
		logic single;
		logic timeout;
		clk_sel_e clk_sel;
		logic cap_mask;
		logic cnt_mask;
		logic pin_sel;
		logic demod;
		logic [1:0] edge_sel;
		omode_e omode;
		logic rise_bit;
		logic fall_bit;
		logic [7:0] reload_high;
		logic [7:0] reload_low;
		logic [7:0] capture_high;
		logic [7:0] capture_low;
		logic [15:0] count;
		logic armed;
		logic ignore;
		logic [2:0] div;
		logic out_level;
		logic pin_out;
		logic timeout_irq;
		logic capture_irq;
		logic narrow_start;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} wcnt_state_s;

endpackage
`default_nettype wire

// ### verilog/wide_counter.sv
// Wide 16-bit down counter with transmit, demodulation and alternating modes, APB slave.
// Register map (byte addresses, one aligned word each, data in bits 7:0):
//   0x00 wide control: bit 7 enable, bit 6 single, bit 5 timeout flag,
//        bits 4:3 clock select, bit 2 capture mask, bit 1 timeout mask,
//        bit 0 pin select.
//   0x04 shared control: bit 6 demodulation, bits 5:4 edge select,
//        bits 3:2 output mode, bit 1 narrow initial level or rising flag,
//        bit 0 wide initial level or falling flag; bit 7 reads zero.
//   0x08 reload high byte, 0x0C reload low byte.
//   0x10 capture high byte, 0x14 capture low byte, both read-only.
// Any other address completes with pslverr, reads zero and writes nothing.
//
// Bus timing: every transfer takes exactly one access cycle. pready is
// registered from the setup cycle, so it is high in the first access
// cycle and low again one clock later; read data and pslverr are
// captured at the same time; pslverr stands for that one cycle only, read data until the next setup.
//
// Counting: a free-running three-bit prescaler produces a tick on every
// first, second, fourth or eighth system clock. On each tick while
// enabled the count steps down by one. The step from one to zero is the
// terminal count; a count that starts at zero wraps to all ones and is
// not a timeout, which is why only the value one is tested.
//
// Transmit: the enable write loads the reload pair and drives the
// initial level; each terminal count toggles the level in normal and
// alternating output modes. Single mode then stops, auto-reload mode
// loads the reload pair again and keeps going.
//
// Demodulation: enable arms the counter, which holds still until the
// first qualifying edge. That edge captures the complemented count,
// loads the reload pair and starts counting, but raises no flag and no
// request. With single clear, every later edge captures, flags,
// requests and reloads all ones. With single set, later edges are
// ignored and a narrow counter timeout takes a snapshot instead.
//
// Alternating: with single set and output mode 01 the terminal count
// clears our enable and pulses narrow_start for one clock; a terminal
// pulse from the narrow counter while we are idle enables us again with
// a fresh load. Writing output mode 00 stops further handoffs.
//
// Output pin: modes 10 and 11 force the pin low or high whether or not
// the counter runs; otherwise a disabled counter shows the inverse of
// its initial level and a running one shows its own level. The pin is
// computed from the next state, so it changes in the same clock as the
// enable or mode write that causes it.
//
// Flags: the timeout flag and, in demodulation, the two edge flags are
// cleared by writing a one. A hardware set in the same clock as such a
// clear wins, so an event is never lost to a late acknowledge.
//
// Reset: asynchronous and active low; all registers but the pin clear, and the pin
// rests high because a disabled counter shows the inverse of a zero
// initial level.
//
// Limitations: a load uses the reload pair as it stood before the clock,
// so a reload write that lands in the same clock as a load is not seen
// by that load. An initial count of one has no defined counting
// behaviour and software must avoid it. Changing the initial-level bit
// while the counter is disabled moves the pin at once, since a disabled
// pin follows the inverse of that bit.
//
// Implementation choices: the register offsets and the APB register port.
`include "wcnt_defines.svh"
`default_nettype none

module wide_counter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic edge_rise,
	input wire logic edge_fall,
	input wire logic narrow_timeout,
	input wire logic narrow_terminal,
	output logic narrow_start,
	output logic wide_counter_output,
	output logic wide_pin_select,
	output logic wide_enabled,
	output logic timeout_irq,
	output logic capture_irq
);
	import wcnt_pkg::*;

	// Registered state and its next value.
	wcnt_state_s state_q;
	wcnt_state_s state_d;

	// Decoded bus strobes and count events.
	logic setup_phase;
	logic wr_access;
	logic tick;
	logic [2:0] div_mask;
	logic tmo_evt;
	logic rise_evt;
	logic fall_evt;
	logic [15:0] reload_val;
	logic [31:0] rd_word;
	logic rd_hit;

	assign setup_phase = psel & ~penable;
	assign wr_access = psel & penable & pwrite & state_q.pready;
	assign reload_val = {state_q.reload_high, state_q.reload_low};

	// The divider runs free, so a change of clock select takes hold within
	// at most eight system clocks rather than restarting the prescaler.
	always_comb begin
		case (state_q.clk_sel)
			CLK_DIV1: div_mask = 3'h0;
			CLK_DIV2: div_mask = 3'h1;
			CLK_DIV4: div_mask = 3'h3;
			CLK_DIV8: div_mask = 3'h7;
			default: div_mask = 3'h0;
		endcase
		tick = ((state_q.div & div_mask) == div_mask);
	end

	// Read multiplexer; unmapped addresses read zero and raise pslverr.
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		case (paddr)
			`WCNT_OFS_WIDE_CTRL: begin
				rd_word[7:0] = {state_q.enable, state_q.single, state_q.timeout,
					state_q.clk_sel, state_q.cap_mask, state_q.cnt_mask, state_q.pin_sel};
			end
			`WCNT_OFS_SHARED_CTRL: begin
				rd_word[7:0] = {1'b0, state_q.demod, state_q.edge_sel, state_q.omode,
					state_q.rise_bit, state_q.fall_bit};
			end
			`WCNT_OFS_RELOAD_HIGH: rd_word[7:0] = state_q.reload_high;
			`WCNT_OFS_RELOAD_LOW: rd_word[7:0] = state_q.reload_low;
			`WCNT_OFS_CAPTURE_HIGH: rd_word[7:0] = state_q.capture_high;
			`WCNT_OFS_CAPTURE_LOW: rd_word[7:0] = state_q.capture_low;
			default: rd_hit = 1'b0;
		endcase
	end

	// Next-state logic: bus writes first, then hardware events, so that an
	// event in the same cycle as a write-one clear still leaves its flag set.
	always_comb begin
		state_d = state_q;
		tmo_evt = 1'b0;
		rise_evt = 1'b0;
		fall_evt = 1'b0;
		state_d.div = state_q.div + 3'h1;
		state_d.timeout_irq = 1'b0;
		state_d.capture_irq = 1'b0;
		state_d.narrow_start = 1'b0;

		// No wait state: pready rises in the first access cycle, data captured at setup.
		state_d.pready = setup_phase;
		if (setup_phase) begin
			state_d.prdata = pwrite ? 32'h0000_0000 : rd_word;
			state_d.pslverr = ~rd_hit;
		end else begin
			state_d.pslverr = 1'b0;
		end

		// Register writes take effect at the completing access edge.
		if (wr_access) begin
			case (paddr)
				`WCNT_OFS_WIDE_CTRL: begin
					state_d.enable = pwdata[`WCNT_CTL_ENABLE];
					state_d.single = pwdata[`WCNT_CTL_SINGLE];
					state_d.clk_sel = clk_sel_e'(pwdata[`WCNT_CTL_CLK_HI:`WCNT_CTL_CLK_LO]);
					state_d.cap_mask = pwdata[`WCNT_CTL_CAP_MASK];
					state_d.cnt_mask = pwdata[`WCNT_CTL_CNT_MASK];
					state_d.pin_sel = pwdata[`WCNT_CTL_PIN_SEL];
					if (pwdata[`WCNT_CTL_TIMEOUT]) begin
						state_d.timeout = 1'b0;
					end
					// A fresh enable loads the programmed value, never a stale count.
					if (pwdata[`WCNT_CTL_ENABLE] && !state_q.enable) begin
						state_d.count = reload_val;
						state_d.out_level = state_q.fall_bit;
						state_d.armed = state_q.demod;
						state_d.ignore = 1'b0;
					end
					// Toggling the single bit low then high re-arms demodulation.
					if (state_q.demod && !state_q.single && pwdata[`WCNT_CTL_SINGLE]) begin
						state_d.armed = 1'b1;
						state_d.ignore = 1'b0;
					end
				end
				`WCNT_OFS_SHARED_CTRL: begin
					state_d.demod = pwdata[`WCNT_SHR_DEMOD];
					state_d.edge_sel = pwdata[`WCNT_SHR_EDGE_HI:`WCNT_SHR_EDGE_LO];
					state_d.omode = omode_e'(pwdata[`WCNT_SHR_OMODE_HI:`WCNT_SHR_OMODE_LO]);
					// In demodulation the low bits are edge flags cleared by a one.
					if (state_q.demod) begin
						if (pwdata[`WCNT_SHR_RISE]) begin
							state_d.rise_bit = 1'b0;
						end
						if (pwdata[`WCNT_SHR_FALL]) begin
							state_d.fall_bit = 1'b0;
						end
					end else begin
						state_d.rise_bit = pwdata[`WCNT_SHR_RISE];
						state_d.fall_bit = pwdata[`WCNT_SHR_FALL];
					end
				end
				// Reload bytes are plain storage and only reach the count on a load.
				`WCNT_OFS_RELOAD_HIGH: state_d.reload_high = pwdata[7:0];
				`WCNT_OFS_RELOAD_LOW: state_d.reload_low = pwdata[7:0];
				default: begin
				end
			endcase
		end

		// Counting, gated by the current enable and the prescaler tick.
		if (state_q.enable && !state_q.armed && tick) begin
			if (state_q.count == `WCNT_ONE) begin
				// Only the step from one to zero is a timeout; zero wraps silently.
				tmo_evt = 1'b1;
				if (state_q.demod) begin
					state_d.count = `WCNT_RST_COUNT;
				end else begin
					if (state_q.omode == OMODE_NORMAL || state_q.omode == OMODE_ALTERNATE) begin
						state_d.out_level = ~state_q.out_level;
					end
					if (state_q.single) begin
						state_d.enable = 1'b0;
						state_d.count = `WCNT_RST_COUNT;
						// Hand the turn to the narrow counter only while alternating.
						state_d.narrow_start = (state_q.omode == OMODE_ALTERNATE);
					end else begin
						state_d.count = reload_val;
					end
				end
			end else begin
				state_d.count = state_q.count - `WCNT_ONE;
			end
		end

		// Demodulation edge handling.
		if (state_q.enable && state_q.demod) begin
			rise_evt = edge_rise & state_q.edge_sel[0];
			fall_evt = edge_fall & state_q.edge_sel[1];
			if (rise_evt || fall_evt) begin
				if (state_q.armed) begin
					// First edge after enable or re-arm: capture and reload.
					state_d.capture_high = ~state_q.count[15:8];
					state_d.capture_low = ~state_q.count[7:0];
					state_d.count = reload_val;
					state_d.armed = 1'b0;
					state_d.ignore = state_q.single;
				end else if (!state_q.ignore && !state_q.single) begin
					state_d.capture_high = ~state_q.count[15:8];
					state_d.capture_low = ~state_q.count[7:0];
					// Build on the next value so a same-clock clear of the other flag holds.
					state_d.rise_bit = state_d.rise_bit | rise_evt;
					state_d.fall_bit = state_d.fall_bit | fall_evt;
					state_d.capture_irq = state_q.cap_mask;
					state_d.count = `WCNT_ALL_ONES;
				end
			end
			// In one-shot demodulation a narrow timeout snapshots without reload.
			if (state_q.single && !state_q.armed && narrow_timeout) begin
				state_d.capture_high = ~state_q.count[15:8];
				state_d.capture_low = ~state_q.count[7:0];
				state_d.capture_irq = state_q.cap_mask;
			end
		end

		// The narrow counter's terminal count hands the turn back to us.
		if (narrow_terminal && state_q.omode == OMODE_ALTERNATE && !state_q.enable
			&& !state_q.demod) begin
			state_d.enable = 1'b1;
			state_d.count = reload_val;
			state_d.out_level = state_q.fall_bit;
		end

		// Timeout flag: the hardware set overrides a simultaneous clear.
		if (tmo_evt) begin
			state_d.timeout = 1'b1;
			state_d.timeout_irq = state_q.cnt_mask;
		end

		// Output pin level, derived from the next state so the pin is registered.
		case (state_d.omode)
			OMODE_FORCE_LOW: state_d.pin_out = 1'b0;
			OMODE_FORCE_HIGH: state_d.pin_out = 1'b1;
			default: begin
				state_d.pin_out = state_d.enable ? state_d.out_level : ~state_d.fall_bit;
			end
		endcase
	end

	// One register process holds the whole block state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= '{
				enable: 1'b0, single: 1'b0, timeout: 1'b0, clk_sel: CLK_DIV1,
				cap_mask: 1'b0, cnt_mask: 1'b0, pin_sel: 1'b0, demod: 1'b0,
				edge_sel: 2'h0, omode: OMODE_NORMAL, rise_bit: 1'b0, fall_bit: 1'b0,
				reload_high: `WCNT_RST_BYTE, reload_low: `WCNT_RST_BYTE,
				capture_high: `WCNT_RST_BYTE, capture_low: `WCNT_RST_BYTE,
				count: `WCNT_RST_COUNT, armed: 1'b0, ignore: 1'b0, div: `WCNT_RST_DIV,
				out_level: 1'b0, pin_out: 1'b1, timeout_irq: 1'b0, capture_irq: 1'b0,
				narrow_start: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000
			};
		end else begin
			state_q <= state_d;
		end
	end

	// All outputs are fields of the registered state.
	assign prdata = state_q.prdata;
	assign pready = state_q.pready;
	assign pslverr = state_q.pslverr;
	assign narrow_start = state_q.narrow_start;
	assign wide_counter_output = state_q.pin_out;
	assign wide_pin_select = state_q.pin_sel;
	assign wide_enabled = state_q.enable;
	assign timeout_irq = state_q.timeout_irq;
	assign capture_irq = state_q.capture_irq;

endmodule // wide_counter
`default_nettype wire

// ### test/wcnt_properties.sv
// Port-level concurrent checks of the wide counter, bound into the design.
`default_nettype none
module wcnt_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic narrow_start,
	input wire logic wide_counter_output,
	input wire logic wide_enabled,
	input wire logic timeout_irq,
	input wire logic capture_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// A write is seen at the edge where it takes effect.
	logic wdone;
	assign wdone = psel && penable && pready && pwrite;
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_error_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("pslverr without pready or with data");
	// The pin is registered, so the forced level is given two edges to show.
	a_force_low_out: assert property (wdone && paddr == 8'h04 && pwdata[3:2] == 2'h2
		|-> ##2 !wide_counter_output) else $error("forced low not seen");
	a_force_high_out: assert property (wdone && paddr == 8'h04 && pwdata[3:2] == 2'h3
		|-> ##2 wide_counter_output) else $error("forced high not seen");
	a_enable_on_write: assert property (wdone && paddr == 8'h00 && pwdata[7] |=> wide_enabled)
		else $error("enable write ignored");
	a_stop_on_write: assert property (wdone && paddr == 8'h00 && !pwdata[7] |=> !wide_enabled)
		else $error("stop write ignored");
	a_handoff_disables: assert property (narrow_start |-> !wide_enabled)
		else $error("handoff left counter enabled");
	a_irq_one_pulse: assert property (timeout_irq |=> !timeout_irq)
		else $error("timeout request too long");
	c_timeout: cover property (timeout_irq);
	c_capture: cover property (capture_irq);
	c_handoff: cover property (narrow_start);
endmodule // wcnt_properties
bind wide_counter wcnt_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .narrow_start(narrow_start),
	.wide_counter_output(wide_counter_output), .wide_enabled(wide_enabled),
	.timeout_irq(timeout_irq), .capture_irq(capture_irq));
`default_nettype wire

// ### test/wcnt_partner.sv
// Model of the input edge circuit and the narrow counter facing the wide counter.
`default_nettype none
module wcnt_partner #(
	parameter int NARROW_LEN = 6
) (
	input wire logic pclk,
	input wire logic narrow_start,
	output var logic edge_rise,
	output var logic edge_fall,
	output var logic narrow_timeout,
	output var logic narrow_terminal
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0; // Cycles left in the narrow counter's own run.
	initial begin
		edge_rise = 0;
		edge_fall = 0;
		narrow_timeout = 0;
		narrow_terminal = 0;
	end
	// The narrow counter runs a fixed length once started, then hands back.
	always @(posedge pclk) begin
		cnt <= narrow_start ? NARROW_LEN : (cnt != 0 ? cnt - 1 : 0);
		narrow_terminal <= (cnt == 1);
	end
	// One-cycle pulse on a chosen line; caller stands just after a rising edge.
	task pulse(input int k);
		if (k == 0) edge_rise <= 1;
		if (k == 1) edge_fall <= 1;
		if (k == 2) narrow_timeout <= 1;
		@(posedge pclk);
		edge_rise <= 0;
		edge_fall <= 0;
		narrow_timeout <= 0;
		@(posedge pclk);
	endtask
endmodule // wcnt_partner
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench of the wide counter over APB.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, er, ef, nto, nterm, nstart, wout, wsel, wen, toirq, capirq;
	logic [7:0] v, v2;
	logic osamp;
	int errors = 0, total_checks = 0, n_to = 0, n_cap = 0, n_ns = 0, n, k;
	always #10 pclk = ~pclk;
	wide_counter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .edge_rise(er), .edge_fall(ef), .narrow_timeout(nto),
		.narrow_terminal(nterm), .narrow_start(nstart), .wide_counter_output(wout),
		.wide_pin_select(wsel), .wide_enabled(wen), .timeout_irq(toirq), .capture_irq(capirq));
	wcnt_partner p (.pclk(pclk), .narrow_start(nstart), .edge_rise(er), .edge_fall(ef),
		.narrow_timeout(nto), .narrow_terminal(nterm));
	// Event counters sample at the falling edge, where outputs have settled.
	always @(negedge pclk) begin
		n_to += (toirq === 1'b1);
		n_cap += (capirq === 1'b1);
		n_ns += (nstart === 1'b1);
	end
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One APB transfer; pready, read data and pslverr are taken at the rising
	// edge that completes the access, before the design updates them.
	task apb(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
		int w;
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		w = 0;
		do begin
			@(posedge pclk);
			w++;
		end while (pready !== 1'b1 && w < 20);
		if (w >= 20) begin
			errors++;
			summarize();
		end
		r = prdata[7:0];
		osamp = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		apb(1, a, d, r);
	endtask
	task rd(input logic [7:0] a, output logic [7:0] r);
		apb(0, a, 8'h00, r);
	endtask
	// Waits for a timeout request; the count is the cycles spent waiting.
	task wait_to(output int c);
		c = 0;
		do begin
			@(negedge pclk);
			c++;
		end while (toirq !== 1'b1 && c < 2000);
		if (c >= 2000) begin
			errors++;
			summarize();
		end
		osamp = wout;
		@(posedge pclk);
	endtask
	task idle(input int c);
		repeat (c) @(posedge pclk);
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk("idle out", 1, wout);
		for (k = 0; k < 6; k++) begin
			rd(8'(k * 4), v);
			chk("reset value", 0, v);
		end
		rd(8'h18, v);
		chk("unmapped error", 1, osamp);
		wr(8'h04, 8'h01);
		idle(2);
		chk("idle inverse", 0, wout);
		wr(8'h04, 8'h0C);
		chk("forced high", 1, wout);
		wr(8'h04, 8'h08);
		chk("forced low", 0, wout);
		wr(8'h04, 8'h01);
		// Zero start: wraps to all ones with no timeout for a long while.
		wr(8'h08, 8'h00);
		wr(8'h0C, 8'h00);
		wr(8'h00, 8'hC2);
		idle(2);
		chk("init level", 1, wout);
		k = n_to;
		idle(100);
		chk("no wrap timeout", k, n_to);
		wr(8'h00, 8'h00);
		wr(8'h04, 8'h00);
		// Auto-reload at every divider: the timeout period is reload times divider.
		wr(8'h0C, 8'h03);
		for (k = 0; k < 4; k++) begin
			wr(8'h00, 8'h82 | 8'(k << 3));
			wait_to(n);
			v = {7'h0, osamp};
			wait_to(n);
			chk("period", 16'(3 << k), 16'(n));
			chk("toggle", {15'h0, ~v[0]}, {15'h0, osamp});
			wr(8'h00, 8'h00);
		end
		rd(8'h00, v);
		chk("timeout bit", 1, v[5]);
		wr(8'h00, 8'h20);
		rd(8'h00, v);
		chk("timeout cleared", 0, v[5]);
		// One-shot stops itself after the first timeout.
		wr(8'h0C, 8'h05);
		wr(8'h00, 8'hC3);
		wait_to(n);
		idle(2);
		chk("one-shot stop", 0, wen);
		chk("pin select", 1, wsel);
		// Demodulation with reload on every edge.
		wr(8'h08, 8'hFF);
		wr(8'h0C, 8'hFF);
		wr(8'h04, 8'h70);
		wr(8'h00, 8'h84);
		k = n_cap;
		p.pulse(0);
		idle(10);
		p.pulse(1);
		idle(2);
		chk("capture requests", k + 1, n_cap);
		rd(8'h14, v);
		chk("capture low range", 1, v >= 8'h08 && v <= 8'h14);
		rd(8'h10, v);
		chk("capture high", 0, v);
		rd(8'h04, v);
		chk("edge flags", 1, v[1:0]);
		wr(8'h04, 8'h71);
		rd(8'h04, v);
		chk("fall flag cleared", 0, v[0]);
		// Re-arm with the single bit, then later edges are ignored.
		wr(8'h00, 8'hC4);
		p.pulse(0);
		rd(8'h14, v);
		k = n_cap;
		p.pulse(1);
		rd(8'h14, v2);
		chk("ignored edge", k, n_cap);
		chk("capture kept", v, v2);
		p.pulse(2);
		idle(2);
		chk("narrow capture", k + 1, n_cap);
		// Alternating handoff with the narrow counter.
		wr(8'h00, 8'h00);
		wr(8'h00, 8'h20);
		wr(8'h04, 8'h04);
		wr(8'h08, 8'h00);
		wr(8'h0C, 8'h04);
		k = n_to;
		wr(8'h00, 8'hC2);
		idle(40);
		chk("handoffs", 1, n_ns >= 2);
		chk("timeouts", 1, n_to >= k + 2);
		wr(8'h04, 8'h00);
		idle(20);
		k = n_ns;
		idle(40);
		chk("handoff ended", k, n_ns);
		summarize();
	end
endmodule // tb_top
`default_nettype wire
